/* File: hdl/fpm_pkg.sv */
/*
 * Constants for the FIFO level and power management register group.
 * Assumes a 12-bit APB byte address and 32-bit data.
 */
package fpm_pkg;

	// --------------------------------------------------------------
	// Register byte addresses
	// --------------------------------------------------------------
	localparam logic [11:0] FPM_RX_FILL_ADDR = 12'h018;
	localparam logic [11:0] FPM_TX_ROOM_ADDR = 12'h01c;
	localparam logic [11:0] FPM_PMT_ADDR     = 12'h020;
	localparam logic [11:0] FPM_IRQ_STS_ADDR = 12'h040;
	localparam logic [11:0] FPM_IRQ_CLR_ADDR = 12'h044;
	localparam logic [11:0] FPM_IRQ_EN_ADDR  = 12'h048;

	// --------------------------------------------------------------
	// Power management control field positions
	// --------------------------------------------------------------
	localparam int FPM_CLR_FLAGS_BIT = 9;
	localparam int FPM_CLR_EN_BIT    = 8;
	localparam int FPM_READY_BIT     = 7;
	localparam int FPM_SUSP_LSB      = 5;
	localparam int FPM_WOL_EN_BIT    = 3;
	localparam int FPM_ED_EN_BIT     = 2;
	localparam int FPM_CAUSE_LSB     = 0;

	// --------------------------------------------------------------
	// Values after reset
	// --------------------------------------------------------------
	localparam logic [15:0] FPM_RX_FILL_RST   = 16'h0000;
	localparam logic [15:0] FPM_TX_ROOM_RST   = 16'h2000;
	localparam logic        FPM_CLR_FLAGS_RST = 1'b0;
	localparam logic        FPM_CLR_EN_RST    = 1'b1;
	localparam logic [1:0]  FPM_SUSP_RST      = 2'b10;

	// --------------------------------------------------------------
	// Interrupt status layout
	// --------------------------------------------------------------
	localparam int FPM_IRQ_W      = 3;
	localparam int FPM_IRQ_WAKE   = 0;
	localparam int FPM_IRQ_READY  = 1;
	localparam int FPM_IRQ_RESUME = 2;

	typedef enum logic [1:0] {
		FPM_SLEEP_ZERO,
		FPM_SLEEP_ONE,
		FPM_SLEEP_TWO,
		FPM_SLEEP_THREE
	} fpm_sleep_t;

endpackage : fpm_pkg

/* File: hdl/fpm_byte_count.sv */
/*
 * Saturating byte counter for a FIFO level.
 * Assumes add and subtract amounts are synchronous to clk_sys.
 */
`timescale 1ns/1ps
module fpm_byte_count
	import fpm_pkg::*;
#(
	parameter logic [15:0] RST_VAL  = 16'h0000,
	parameter logic        ROUND_UP = 1'b0
)(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        addEn,
	input  wire logic [15:0] addBytes,
	input  wire logic        subEn,
	input  wire logic [15:0] subBytes,
	output logic      [15:0] count
);

	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [16:0] addAmt;
	logic [17:0] sum;

	always_comb begin
		// Partial last word still takes a whole word of FIFO
		if (ROUND_UP && (addBytes[1:0] != 2'h0))
			addAmt = {1'b0, addBytes[15:2], 2'h0} + 17'h00004;
		else
			addAmt = {1'b0, addBytes};
		sum = {2'h0, count_r} + (addEn ? {1'b0, addAmt} : 18'h00000) - (subEn ? {2'h0, subBytes} : 18'h00000);
		// Clamp rather than wrap, so a bad event cannot fake a huge level
		if (sum[17])
			count_nxt = 16'h0000;
		else if (sum[16])
			count_nxt = 16'hffff;
		else
			count_nxt = sum[15:0];
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			count_r <= RST_VAL;
		else
			count_r <= count_nxt;
	end

	assign count = count_r;

endmodule : fpm_byte_count

/* File: hdl/fpm_regs.sv */
/*
 * FIFO level and power management registers behind an APB slave.
 * Assumes all event inputs are one-cycle pulses synchronous to clk_sys,
 * and that the wake status flags and other wake enables live elsewhere.
 */
`timescale 1ns/1ps
module fpm_regs
	import fpm_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        rxFrameDone,
	input  wire logic [15:0] rxFrameLen,
	input  wire logic        rxDrainDone,
	input  wire logic [15:0] rxDrainBytes,
	input  wire logic        txLoadDone,
	input  wire logic [15:0] txLoadBytes,
	input  wire logic        txSendDone,
	input  wire logic [15:0] txSendBytes,
	input  wire logic        resumeDone,
	input  wire logic        resumeRemote,
	input  wire logic [1:0]  wakeCauseSet,
	input  wire logic        normalState,
	input  wire logic        configDone,
	input  wire logic        phyClockOk,
	input  wire logic        watchdogExpired,
	input  wire logic        deconfigure,
	output logic             wakeFlagsClear,
	output logic             wolWakeOn,
	output logic             energyWakeOn,
	output logic      [3:0]  sleepVariant,
	output logic             irq
);

	// ------------------------------------------------------------------
	// FIFO level counters
	// ------------------------------------------------------------------
	logic [15:0] rxFill;
	logic [15:0] txRoom;

	fpm_byte_count #(
		.RST_VAL  (FPM_RX_FILL_RST),
		.ROUND_UP (1'b1)
	) u_rx_fill (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.addEn    (rxFrameDone),
		.addBytes (rxFrameLen),
		.subEn    (rxDrainDone),
		.subBytes (rxDrainBytes),
		.count    (rxFill)
	);

	// Room grows as bytes leave and shrinks as the host loads them
	fpm_byte_count #(
		.RST_VAL  (FPM_TX_ROOM_RST),
		.ROUND_UP (1'b0)
	) u_tx_room (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.addEn    (txSendDone),
		.addBytes (txSendBytes),
		.subEn    (txLoadDone),
		.subBytes (txLoadBytes),
		.count    (txRoom)
	);

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	logic apbSetup;
	logic apbWr;
	logic addrHit;
	logic pmtWr;

	always_comb begin
		addrHit = (paddr == FPM_RX_FILL_ADDR) || (paddr == FPM_TX_ROOM_ADDR) ||
		          (paddr == FPM_PMT_ADDR) || (paddr == FPM_IRQ_STS_ADDR) ||
		          (paddr == FPM_IRQ_CLR_ADDR) || (paddr == FPM_IRQ_EN_ADDR);
	end

	assign apbSetup = psel && !penable;
	assign apbWr    = psel && penable && pwrite && addrHit;
	assign pmtWr    = apbWr && (paddr == FPM_PMT_ADDR);
	// Zero wait states: read data is captured in the setup cycle
	assign pready   = psel && penable;
	assign pslverr  = psel && penable && !addrHit;

	// ------------------------------------------------------------------
	// Power management control state
	// ------------------------------------------------------------------
	logic       clrFlags_r;
	logic       clrFlags_nxt;
	logic       clrEn_r;
	logic       clrEn_nxt;
	logic       ready_r;
	logic       ready_nxt;
	logic [1:0] suspendMode_r;
	logic [1:0] suspendMode_nxt;
	logic       wolEn_r;
	logic       wolEn_nxt;
	logic       edEn_r;
	logic       edEn_nxt;
	logic [1:0] wakeCause_r;
	logic [1:0] wakeCause_nxt;
	logic       flagsClr_r;
	logic       flagsClr_nxt;
	logic [3:0] variant_r;
	logic [3:0] variant_nxt;
	logic       resumeClrFlags;
	logic       resumeClrEn;

	always_comb begin
		clrFlags_nxt    = clrFlags_r;
		clrEn_nxt       = clrEn_r;
		suspendMode_nxt = suspendMode_r;
		wolEn_nxt       = wolEn_r;
		edEn_nxt        = edEn_r;
		wakeCause_nxt   = wakeCause_r;
		resumeClrFlags  = resumeDone && clrFlags_r;
		// Host-started resumes never touch the enables
		resumeClrEn     = resumeDone && resumeRemote && clrEn_r;
		// Only the energy-detect and link-wake enables are held here
		if (resumeClrEn) begin
			wolEn_nxt = 1'b0;
			edEn_nxt  = 1'b0;
		end
		if (resumeClrFlags)
			wakeCause_nxt[1] = 1'b0;
		if (pmtWr && pstrb[1]) begin
			clrFlags_nxt = pwdata[FPM_CLR_FLAGS_BIT];
			clrEn_nxt    = pwdata[FPM_CLR_EN_BIT];
		end
		if (pmtWr && pstrb[0]) begin
			suspendMode_nxt = pwdata[FPM_SUSP_LSB +: 2];
			wolEn_nxt       = pwdata[FPM_WOL_EN_BIT];
			edEn_nxt        = pwdata[FPM_ED_EN_BIT];
			wakeCause_nxt   = wakeCause_nxt & ~pwdata[FPM_CAUSE_LSB +: 2];
		end
		// A new cause wins over a clear in the same cycle
		wakeCause_nxt = wakeCause_nxt | wakeCauseSet;
		if (deconfigure)
			suspendMode_nxt = FPM_SUSP_RST;
		// Without PHY clocks only the watchdog completes the reset
		ready_nxt    = normalState && configDone && (phyClockOk || watchdogExpired);
		flagsClr_nxt = resumeClrFlags;
		variant_nxt  = 4'h0;
		unique case (fpm_sleep_t'(suspendMode_nxt))
			FPM_SLEEP_ZERO:  variant_nxt[0] = 1'b1;
			FPM_SLEEP_ONE:   variant_nxt[1] = 1'b1;
			FPM_SLEEP_TWO:   variant_nxt[2] = 1'b1;
			FPM_SLEEP_THREE: variant_nxt[3] = 1'b1;
		endcase
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			clrFlags_r    <= FPM_CLR_FLAGS_RST;
			clrEn_r       <= FPM_CLR_EN_RST;
			ready_r       <= 1'b0;
			suspendMode_r <= FPM_SUSP_RST;
			wolEn_r       <= 1'b0;
			edEn_r        <= 1'b0;
			wakeCause_r   <= 2'h0;
			flagsClr_r    <= 1'b0;
			variant_r     <= 4'h4;
		end else begin
			clrFlags_r    <= clrFlags_nxt;
			clrEn_r       <= clrEn_nxt;
			ready_r       <= ready_nxt;
			suspendMode_r <= suspendMode_nxt;
			wolEn_r       <= wolEn_nxt;
			edEn_r        <= edEn_nxt;
			wakeCause_r   <= wakeCause_nxt;
			flagsClr_r    <= flagsClr_nxt;
			variant_r     <= variant_nxt;
		end
	end

	assign wakeFlagsClear = flagsClr_r;
	assign wolWakeOn      = wolEn_r;
	assign energyWakeOn   = edEn_r;
	assign sleepVariant   = variant_r;

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	logic [FPM_IRQ_W-1:0] irqSts_r;
	logic [FPM_IRQ_W-1:0] irqSts_nxt;
	logic [FPM_IRQ_W-1:0] irqEn_r;
	logic [FPM_IRQ_W-1:0] irqEn_nxt;
	logic [FPM_IRQ_W-1:0] irqEvt;
	logic                 irq_r;
	logic                 irq_nxt;

	always_comb begin
		irqEvt                 = '0;
		irqEvt[FPM_IRQ_WAKE]   = |wakeCauseSet;
		irqEvt[FPM_IRQ_READY]  = ready_nxt && !ready_r;
		irqEvt[FPM_IRQ_RESUME] = resumeDone;
		irqSts_nxt             = irqSts_r;
		irqEn_nxt              = irqEn_r;
		if (apbWr && pstrb[0] && (paddr == FPM_IRQ_CLR_ADDR))
			irqSts_nxt = irqSts_nxt & ~pwdata[FPM_IRQ_W-1:0];
		if (apbWr && pstrb[0] && (paddr == FPM_IRQ_EN_ADDR))
			irqEn_nxt = pwdata[FPM_IRQ_W-1:0];
		// Set wins over a clear in the same cycle
		irqSts_nxt = irqSts_nxt | irqEvt;
		irq_nxt    = |(irqSts_nxt & irqEn_nxt);
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irqSts_r <= '0;
			irqEn_r  <= '0;
			irq_r    <= 1'b0;
		end else begin
			irqSts_r <= irqSts_nxt;
			irqEn_r  <= irqEn_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign irq = irq_r;

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (apbSetup) begin
			rdata_nxt = 32'h00000000;
			unique case (paddr)
				FPM_RX_FILL_ADDR: rdata_nxt[15:0] = rxFill;
				FPM_TX_ROOM_ADDR: rdata_nxt[15:0] = txRoom;
				FPM_PMT_ADDR: begin
					rdata_nxt[FPM_CLR_FLAGS_BIT]    = clrFlags_r;
					rdata_nxt[FPM_CLR_EN_BIT]       = clrEn_r;
					rdata_nxt[FPM_READY_BIT]        = ready_r;
					rdata_nxt[FPM_SUSP_LSB +: 2]    = suspendMode_r;
					rdata_nxt[FPM_WOL_EN_BIT]       = wolEn_r;
					rdata_nxt[FPM_ED_EN_BIT]        = edEn_r;
					rdata_nxt[FPM_CAUSE_LSB +: 2]   = wakeCause_r;
				end
				FPM_IRQ_STS_ADDR: rdata_nxt[FPM_IRQ_W-1:0] = irqSts_r;
				FPM_IRQ_EN_ADDR:  rdata_nxt[FPM_IRQ_W-1:0] = irqEn_r;
				default:          rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn)
			rdata_r <= 32'h00000000;
		else
			rdata_r <= rdata_nxt;
	end

	assign prdata = rdata_r;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	logic [15:0] lenRounded;

	always_comb begin
		lenRounded = (rxFrameLen[1:0] != 2'h0) ? ({rxFrameLen[15:2], 2'h0} + 16'h0004) : rxFrameLen;
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	sequence noClockWait;
		(!phyClockOk && !watchdogExpired)[*2];
	endsequence

	sequence remoteResume;
		resumeDone && resumeRemote && clrEn_r && !pmtWr;
	endsequence

	sequence hostResume;
		resumeDone && !resumeRemote && !pmtWr;
	endsequence

	a_rx_round_add: assert property (rxFrameDone && !rxDrainDone && rxFill < 16'hefff && rxFrameLen < 16'h1000
		|=> rxFill == $past(rxFill) + $past(lenRounded))
		else $error("receive fill not advanced by rounded length");
	a_resume_flags_clear: assert property (resumeDone && clrFlags_r |=> wakeFlagsClear)
		else $error("wake flags not cleared after resume");
	a_resume_flags_keep: assert property (resumeDone && !clrFlags_r |=> !wakeFlagsClear)
		else $error("wake flags cleared with clear bit off");
	a_cause_hi_clear: assert property (resumeDone && clrFlags_r && !wakeCauseSet[1] |=> !wakeCause_r[1])
		else $error("upper wake cause kept after resume");
	a_remote_en_clear: assert property (remoteResume |=> !wolWakeOn && !energyWakeOn)
		else $error("enables kept after remote resume");
	a_host_en_keep: assert property (hostResume |=> $stable(wolWakeOn) && $stable(energyWakeOn))
		else $error("enables changed by host resume");
	a_ready_cause: assert property (ready_r |-> $past(normalState) && $past(configDone))
		else $error("ready without normal configured state");
	a_ready_wdog_wait: assert property (noClockWait |-> !ready_r)
		else $error("ready before watchdog without PHY clock");
	a_decon_susp: assert property (deconfigure |=> suspendMode_r == FPM_SUSP_RST && sleepVariant[2])
		else $error("suspend select not forced on deconfigure");
	a_variant_match: assert property ($onehot(sleepVariant) && sleepVariant[suspendMode_r])
		else $error("sleep variant does not follow select");
	a_cause_w1c: assert property (pmtWr && pstrb[0] && pwdata[0] && !wakeCauseSet[0] |=> !wakeCause_r[0])
		else $error("wake cause bit not cleared by write one");

endmodule : fpm_regs

/* File: tb/fpm_tb.sv */
/*
 * Self-checking bench for the FIFO level and power management registers.
 * Assumes the zero-wait APB slave, pulse event inputs and the reset values of fpm_pkg.
 */
`timescale 1ns/1ps
module tb
	import fpm_pkg::*;
;
	logic        clk_sys, resetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0]  pstrb, sleepVariant;
	logic        pready, pslverr, err, irq, wakeFlagsClear, wolWakeOn, energyWakeOn;
	logic        rxFrameDone, rxDrainDone, txLoadDone, txSendDone, resumeDone, resumeRemote;
	logic [15:0] rxFrameLen, rxDrainBytes, txLoadBytes, txSendBytes;
	logic [1:0]  wakeCauseSet;
	logic        normalState, configDone, phyClockOk, watchdogExpired, deconfigure;
	int          n_fail, tests_run;

	fpm_regs uut (.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxFrameDone(rxFrameDone), .rxFrameLen(rxFrameLen),
		.rxDrainDone(rxDrainDone), .rxDrainBytes(rxDrainBytes), .txLoadDone(txLoadDone),
		.txLoadBytes(txLoadBytes), .txSendDone(txSendDone), .txSendBytes(txSendBytes),
		.resumeDone(resumeDone), .resumeRemote(resumeRemote), .wakeCauseSet(wakeCauseSet),
		.normalState(normalState), .configDone(configDone), .phyClockOk(phyClockOk),
		.watchdogExpired(watchdogExpired), .deconfigure(deconfigure),
		.wakeFlagsClear(wakeFlagsClear), .wolWakeOn(wolWakeOn), .energyWakeOn(energyWakeOn),
		.sleepVariant(sleepVariant), .irq(irq));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// --------------------------------------------------------------
	// Checking and bus tasks
	// --------------------------------------------------------------
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Request held until pready is sampled high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= wr;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask : apb

	task automatic rd(input string name, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, q, exp);
	endtask : rd

	// Pulse with a chosen link, wake flag clear seen in the cycle after only
	task automatic resume(input logic remote, input logic expClr);
		@(posedge clk_sys);
		resumeDone   <= 1'b1;
		resumeRemote <= remote;
		@(posedge clk_sys);
		resumeDone <= 1'b0;
		#1 chk("wakeFlagsClear", 32'(wakeFlagsClear), 32'(expClr));
		@(posedge clk_sys);
		#1 chk("wakeFlagsClear end", 32'(wakeFlagsClear), 32'h0);
	endtask : resume

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		{rxFrameDone, rxDrainDone, txLoadDone, txSendDone, resumeDone, resumeRemote} = '0;
		{rxFrameLen, rxDrainBytes, txLoadBytes, txSendBytes, wakeCauseSet} = '0;
		{normalState, configDone, phyClockOk, watchdogExpired, deconfigure} = '0;
		n_fail = 0;
		tests_run = 0;
		resetn = 1'b0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;

		rd("rx fill rst", FPM_RX_FILL_ADDR, 32'h0000);
		rd("tx room rst", FPM_TX_ROOM_ADDR, 32'h2000);
		rd("pmt rst", FPM_PMT_ADDR, 32'h0000_0140);
		chk("sleepVariant rst", 32'(sleepVariant), 32'h4);
		$display("test reset done");

		// Odd length rounds up to whole words
		@(posedge clk_sys);
		rxFrameDone <= 1'b1;
		rxFrameLen  <= 16'h0005;
		@(posedge clk_sys);
		rxFrameLen  <= 16'h0008;
		@(posedge clk_sys);
		rxFrameDone <= 1'b0;
		rd("rx fill", FPM_RX_FILL_ADDR, 32'h0010);
		@(posedge clk_sys);
		rxDrainDone  <= 1'b1;
		rxDrainBytes <= 16'h0010;
		txLoadDone   <= 1'b1;
		txLoadBytes  <= 16'h0010;
		@(posedge clk_sys);
		{rxDrainDone, txLoadDone} <= 2'b00;
		rd("rx drained", FPM_RX_FILL_ADDR, 32'h0000);
		rd("tx room", FPM_TX_ROOM_ADDR, 32'h1ff0);
		apb(1'b1, FPM_TX_ROOM_ADDR, 32'h0);
		rd("tx room ro", FPM_TX_ROOM_ADDR, 32'h1ff0);
		$display("test fifo levels done");

		for (int s = 0; s < 4; s++) begin
			apb(1'b1, FPM_PMT_ADDR, 32'h100 | (s << FPM_SUSP_LSB));
			rd("pmt suspend", FPM_PMT_ADDR, 32'h100 | (s << FPM_SUSP_LSB));
			chk("sleepVariant", 32'(sleepVariant), 32'h1 << s);
		end
		@(posedge clk_sys);
		deconfigure <= 1'b1;
		@(posedge clk_sys);
		deconfigure <= 1'b0;
		rd("pmt deconfig", FPM_PMT_ADDR, 32'h140);
		$display("test suspend select done");

		apb(1'b1, FPM_IRQ_EN_ADDR, 32'h7);
		{normalState, configDone} <= 2'b11;
		repeat (4) @(posedge clk_sys);
		rd("ready no phy clock", FPM_PMT_ADDR, 32'h140);
		watchdogExpired <= 1'b1;
		rd("ready", FPM_PMT_ADDR, 32'h1c0);
		rd("irq sts ready", FPM_IRQ_STS_ADDR, 32'h2);
		chk("irq ready", 32'(irq), 32'h1);
		apb(1'b1, FPM_IRQ_CLR_ADDR, 32'h2);
		rd("irq sts clr", FPM_IRQ_STS_ADDR, 32'h0);
		chk("irq cleared", 32'(irq), 32'h0);
		$display("test ready done");

		// Keep the select at 10b, the value deconfigure loaded, and set both wake enables
		apb(1'b1, FPM_PMT_ADDR, 32'h14c);
		#1 chk("wolWakeOn", 32'(wolWakeOn), 32'h1);
		chk("energyWakeOn", 32'(energyWakeOn), 32'h1);
		@(posedge clk_sys);
		wakeCauseSet <= 2'b11;
		@(posedge clk_sys);
		wakeCauseSet <= 2'b00;
		rd("pmt cause", FPM_PMT_ADDR, 32'h1cf);
		resume(1'b0, 1'b0);
		rd("pmt host resume", FPM_PMT_ADDR, 32'h1cf);
		apb(1'b1, FPM_PMT_ADDR, 32'h34c);
		resume(1'b1, 1'b1);
		rd("pmt remote resume", FPM_PMT_ADDR, 32'h3c1);
		chk("wolWakeOn cleared", 32'(wolWakeOn), 32'h0);
		apb(1'b1, FPM_PMT_ADDR, 32'h341);
		rd("pmt cause w1c", FPM_PMT_ADDR, 32'h3c0);
		$display("test wake done");

		rd("irq sts wake", FPM_IRQ_STS_ADDR, 32'h5);
		chk("irq wake", 32'(irq), 32'h1);
		apb(1'b1, FPM_IRQ_EN_ADDR, 32'h0);
		rd("irq en", FPM_IRQ_EN_ADDR, 32'h0);
		chk("irq masked", 32'(irq), 32'h0);
		apb(1'b1, FPM_IRQ_CLR_ADDR, 32'h7);
		rd("irq sts end", FPM_IRQ_STS_ADDR, 32'h0);
		rd("unmapped data", 12'h0fc, 32'h0);
		chk("unmapped err", 32'(err), 32'h1);
		$display("test interrupts done");
		complete_run();
	end
endmodule : tb
